//--- rtl/alu_pkg.sv
/*
   Types of the ALU datapath: operations, condition codes, operand sources.
   Assumes nothing of its surroundings.
*/
package alu_pkg;

   typedef enum logic [4:0] {
      op_add, op_add_with_carry, op_sub, op_subtract_with_carry,
      op_reverse_subtract, op_and, op_or, op_and_with_inverse, op_xor,
      op_max, op_min, op_mov, op_single_bit_set, op_single_bit_clear,
      op_single_bit_toggle, op_low_bit_mask, op_scaled_add_by_two,
      op_scaled_add_by_four, op_scaled_add_by_eight, op_scaled_subtract_by_two,
      op_scaled_subtract_by_four, op_scaled_subtract_by_eight,
      op_asl, op_asr, op_lsr, op_ror
   } op_e;

   typedef enum logic [3:0] {
      cond_always, cond_zero, cond_nonzero, cond_positive, cond_negative,
      cond_carry, cond_no_carry, cond_overflow, cond_no_overflow,
      cond_gt, cond_ge, cond_lt, cond_le, cond_hi, cond_ls, cond_pnz
   } cond_e;

   typedef enum logic [2:0] {
      src2_reg, src2_u6, src2_s12, src2_limm, src2_u3, src2_u5, src2_u7, src2_u7_words
   } src2_e;

endpackage

//--- rtl/alu_regs.svh
/*
   Register offsets, field positions and reset values of the ALU datapath.
   Assumes a 12-bit APB byte address and 32-bit data.
*/
`ifndef ALU_REGS_SVH
`define ALU_REGS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_INSN 12'h000
`define OFS_FIELDS 12'h004
`define OFS_IMM 12'h008
`define OFS_LIMM 12'h00c
`define OFS_GO 12'h010
`define OFS_STATUS 12'h014
`define OFS_RESULT 12'h018
`define RF_BASE_HI 4'h1

// ----------------------------------------
// Instruction register fields
// ----------------------------------------
`define INSN_OP 4:0
`define INSN_SHORT 5
`define INSN_SETF 6
`define INSN_CC 10:7
`define INSN_SRC1_LIMM 11
`define INSN_SRC2 14:12
`define INSN_C_FULL 15

// ----------------------------------------
// Operand field register and immediate
// ----------------------------------------
`define FLD_A 5:0
`define FLD_B 13:8
`define FLD_C 21:16
`define IMM_U3 2:0
`define IMM_U5 4:0
`define IMM_U7 6:0
`define IMM_S12 11:0

// ----------------------------------------
// Status register bits
// ----------------------------------------
`define FLG_Z 0
`define FLG_N 1
`define FLG_C 2
`define FLG_V 3
`define ST_FLAGS 3:0
`define ST_REFUSED 4
`define ST_SKIPPED 5
`define ST_DONE 6

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_WORD 32'h0000_0000
`define RST_FLAGS 4'h0

`endif

//--- rtl/base_alu_datapath.sv
/*
   Integer ALU datapath with its core register file, driven over APB.
   Software loads operands, an instruction descriptor and writes GO; the
   result commits one cycle later. Assumes a single APB master on pclk.
*/
// What this block does
// - Short-form flag selects 16-bit decoding; otherwise decode as 32-bit.
// - 16-bit register fields reach only the reduced subset; field C reaches all registers under full range.
// - Immediates are zero- or sign-extended from their field width.
// - Every operation may be condition-gated, flag-setting, or both.
// - Long-form destination field zero computes but writes no register.
// - Long immediate may replace source one or source two.
// - Add with carry adds both operands plus carry.
// - Subtract with carry subtracts second operand then carry.
// - Reverse subtract returns second operand minus first.
// - And-with-inverse ANDs first operand with inverted second.
// - Bitwise XOR, AND and OR of both operands.
// - Max and min compare signed and pick larger or smaller.
// - Single-bit set, clear, toggle, and low mask up to selected bit.
// - Scaled add adds second operand shifted left one, two or three.
// - Scaled subtract subtracts second operand shifted left one, two, three.
// - Shift left, arithmetic right, logical right, rotate right by operand.
// - No 16-bit form for carry ops, reverse, scaled subtract, rotate, min, max.
// - 16-bit add may use stack and global pointers through full-range field.
// - 16-bit self-subtract clears register only when zero flag is clear.
// - 16-bit stack pointer subtract scales its 7-bit offset to words.
`include "alu_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module base_alu_datapath
#(
   parameter logic [5:0] REDUCED_HI_BASE = 6'h0c,
   parameter logic [5:0] STACK_POINTER = 6'h1c,
   parameter logic [5:0] GLOBAL_POINTER = 6'h1a
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] r;
      for (int i = 0; i < 4; i++)
         r[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
      return r;
   endfunction
   function automatic logic [5:0] reg_index(input logic [5:0] code, input logic short_f,
                                            input logic full);
      return (!short_f || full) ? code
             : (code[2] ? (REDUCED_HI_BASE + {4'h0, code[1:0]}) : {4'h0, code[1:0]});
   endfunction
   function automatic logic cond_ok(input alu_pkg::cond_e cc, input logic [3:0] f);
      logic r;
      unique case (cc)
         alu_pkg::cond_always: r = 1'b1;
         alu_pkg::cond_zero: r = f[`FLG_Z];
         alu_pkg::cond_nonzero: r = !f[`FLG_Z];
         alu_pkg::cond_positive: r = !f[`FLG_N];
         alu_pkg::cond_negative: r = f[`FLG_N];
         alu_pkg::cond_carry: r = f[`FLG_C];
         alu_pkg::cond_no_carry: r = !f[`FLG_C];
         alu_pkg::cond_overflow: r = f[`FLG_V];
         alu_pkg::cond_no_overflow: r = !f[`FLG_V];
         alu_pkg::cond_gt: r = (f[`FLG_N] == f[`FLG_V]) && !f[`FLG_Z];
         alu_pkg::cond_ge: r = (f[`FLG_N] == f[`FLG_V]);
         alu_pkg::cond_lt: r = (f[`FLG_N] != f[`FLG_V]);
         alu_pkg::cond_le: r = (f[`FLG_N] != f[`FLG_V]) || f[`FLG_Z];
         alu_pkg::cond_hi: r = !f[`FLG_C] && !f[`FLG_Z];
         alu_pkg::cond_ls: r = f[`FLG_C] || f[`FLG_Z];
         alu_pkg::cond_pnz: r = !f[`FLG_N] && !f[`FLG_Z];
      endcase
      return r;
   endfunction

   function automatic logic [32:0] add33(input logic [31:0] x, input logic [31:0] y,
                                         input logic ci);
      return {1'b0, x} + {1'b0, y} + {32'h0, ci};
   endfunction

   // ----------------------------------------
   // State
   // ----------------------------------------
   logic [31:0] rf [64];
   logic [31:0] insn;
   logic [31:0] fields;
   logic [31:0] imm;
   logic [31:0] limm;
   logic [31:0] result;
   logic [3:0] flags;
   logic refused_q;
   logic skipped_q;
   logic done_q;
   logic go;

   // ----------------------------------------
   // APB decode
   // ----------------------------------------
   wire logic access = psel && penable && !pready;
   wire logic wr = access && pwrite;
   wire logic hit_insn = paddr == `OFS_INSN;
   wire logic hit_fields = paddr == `OFS_FIELDS;
   wire logic hit_imm = paddr == `OFS_IMM;
   wire logic hit_limm = paddr == `OFS_LIMM;
   wire logic hit_go = paddr == `OFS_GO;
   wire logic hit_status = paddr == `OFS_STATUS;
   wire logic hit_result = paddr == `OFS_RESULT;
   wire logic hit_rf = (paddr[11:8] == `RF_BASE_HI) && (paddr[1:0] == 2'h0);
   wire logic [5:0] rf_addr = paddr[7:2];
   wire logic mapped = hit_insn || hit_fields || hit_imm || hit_limm || hit_go
                       || hit_status || hit_result || hit_rf;
   wire logic [31:0] status_word = {25'h0, done_q, skipped_q, refused_q, flags};
   wire logic [31:0] rdata_mux = hit_insn ? insn :
                                 hit_fields ? fields :
                                 hit_imm ? imm :
                                 hit_limm ? limm :
                                 hit_status ? status_word :
                                 hit_result ? result :
                                 hit_rf ? rf[rf_addr] : `RST_WORD;

   // ----------------------------------------
   // Instruction decode
   // ----------------------------------------
   wire alu_pkg::op_e op = alu_pkg::op_e'(insn[`INSN_OP]);
   wire alu_pkg::cond_e cc = alu_pkg::cond_e'(insn[`INSN_CC]);
   wire alu_pkg::src2_e kind = alu_pkg::src2_e'(insn[`INSN_SRC2]);
   wire logic short_f = insn[`INSN_SHORT];
   wire logic setf = insn[`INSN_SETF];
   wire logic [5:0] fa = fields[`FLD_A];
   wire logic [5:0] fb = fields[`FLD_B];
   wire logic [5:0] fc = fields[`FLD_C];
   wire logic sp_form = short_f && (kind == alu_pkg::src2_u7_words);
   wire logic [5:0] idx_a = sp_form ? STACK_POINTER : reg_index(fa, short_f, 1'b0);
   wire logic [5:0] idx_b = sp_form ? STACK_POINTER : reg_index(fb, short_f, 1'b0);
   wire logic [5:0] idx_c = reg_index(fc, short_f, insn[`INSN_C_FULL]);
   wire logic [31:0] opnd_b = insn[`INSN_SRC1_LIMM] ? limm : rf[idx_b];
   logic [31:0] opnd_c;
   always_comb
   begin
      unique case (kind)
         alu_pkg::src2_reg: opnd_c = rf[idx_c];
         alu_pkg::src2_u6: opnd_c = {26'h0, fc};
         alu_pkg::src2_s12: opnd_c = {{20{imm[11]}}, imm[`IMM_S12]};
         alu_pkg::src2_limm: opnd_c = limm;
         alu_pkg::src2_u3: opnd_c = {29'h0, imm[`IMM_U3]};
         alu_pkg::src2_u5: opnd_c = {27'h0, imm[`IMM_U5]};
         alu_pkg::src2_u7: opnd_c = {25'h0, imm[`IMM_U7]};
         alu_pkg::src2_u7_words: opnd_c = {23'h0, imm[`IMM_U7], 2'h0};
      endcase
   end

   wire logic self_clear = short_f && (op == alu_pkg::op_sub) && (kind == alu_pkg::src2_reg)
                           && (fa == fb) && (fb == fc);
   wire alu_pkg::cond_e eff_cc = self_clear ? alu_pkg::cond_nonzero : cc;
   wire logic no_short_form = (insn[`INSN_OP] > 5'h19) || (op inside {alu_pkg::op_ror,
                              alu_pkg::op_add_with_carry, alu_pkg::op_subtract_with_carry,
                              alu_pkg::op_reverse_subtract, alu_pkg::op_scaled_subtract_by_two,
                              alu_pkg::op_scaled_subtract_by_four, alu_pkg::op_min,
                              alu_pkg::op_scaled_subtract_by_eight, alu_pkg::op_max});
   wire logic refused = short_f && no_short_form;
   wire logic cond_pass = cond_ok(eff_cc, flags);
   wire logic discard = !short_f && (fa == 6'h0);

   // ----------------------------------------
   // Adder, shifter and logic unit
   // ----------------------------------------
   logic [31:0] ax;
   logic [31:0] ay;
   logic ci;
   logic borrow;
   logic [32:0] sum;
   logic add_v;
   logic [4:0] shamt;
   logic [31:0] bit_mask;
   logic [32:0] shl;
   logic [32:0] shr;
   logic [63:0] rot;
   logic lt;
   logic [31:0] res;
   logic c_out;
   logic v_out;
   logic upd_cv;

   always_comb
   begin
      ax = opnd_b;
      ay = opnd_c;
      ci = 1'b0;
      borrow = 1'b0;
      unique case (op)
         alu_pkg::op_add_with_carry: ci = flags[`FLG_C];
         alu_pkg::op_sub, alu_pkg::op_max, alu_pkg::op_min:
         begin
            ay = ~opnd_c;
            ci = 1'b1;
            borrow = 1'b1;
         end
         alu_pkg::op_subtract_with_carry:
         begin
            ay = ~opnd_c;
            ci = !flags[`FLG_C];
            borrow = 1'b1;
         end
         alu_pkg::op_reverse_subtract:
         begin
            ax = opnd_c;
            ay = ~opnd_b;
            ci = 1'b1;
            borrow = 1'b1;
         end
         alu_pkg::op_scaled_add_by_two: ay = opnd_c << 1;
         alu_pkg::op_scaled_add_by_four: ay = opnd_c << 2;
         alu_pkg::op_scaled_add_by_eight: ay = opnd_c << 3;
         alu_pkg::op_scaled_subtract_by_two, alu_pkg::op_scaled_subtract_by_four,
         alu_pkg::op_scaled_subtract_by_eight:
         begin
            ay = ~(opnd_c << (insn[1:0] - 2'h2));
            ci = 1'b1;
            borrow = 1'b1;
         end
         default: ;
      endcase
      sum = add33(ax, ay, ci);
      add_v = (ax[31] == ay[31]) && (sum[31] != ax[31]);
      lt = sum[31] ^ add_v;
      shamt = opnd_c[4:0];
      bit_mask = 32'h1 << shamt;
      shl = {1'b0, opnd_b} << shamt;
      shr = (op == alu_pkg::op_asr) ? 33'($signed({opnd_b, 1'b0}) >>> shamt)
                                    : ({opnd_b, 1'b0} >> shamt);
      rot = {opnd_b, opnd_b} >> shamt;
      res = sum[31:0];
      c_out = sum[32] ^ borrow;
      v_out = add_v;
      unique case (op)
         alu_pkg::op_and: res = opnd_b & opnd_c;
         alu_pkg::op_or: res = opnd_b | opnd_c;
         alu_pkg::op_xor: res = opnd_b ^ opnd_c;
         alu_pkg::op_and_with_inverse: res = opnd_b & ~opnd_c;
         alu_pkg::op_max: res = lt ? opnd_c : opnd_b;
         alu_pkg::op_min: res = lt ? opnd_b : opnd_c;
         alu_pkg::op_mov: res = opnd_c;
         alu_pkg::op_single_bit_set: res = opnd_b | bit_mask;
         alu_pkg::op_single_bit_clear: res = opnd_b & ~bit_mask;
         alu_pkg::op_single_bit_toggle: res = opnd_b ^ bit_mask;
         alu_pkg::op_low_bit_mask: res = opnd_b & ((bit_mask << 1) - 32'h1);
         alu_pkg::op_asl:
         begin
            res = shl[31:0];
            c_out = (shamt != 5'h0) ? shl[32] : flags[`FLG_C];
            v_out = flags[`FLG_V];
         end
         alu_pkg::op_asr, alu_pkg::op_lsr:
         begin
            res = shr[32:1];
            c_out = (shamt != 5'h0) ? shr[0] : flags[`FLG_C];
            v_out = flags[`FLG_V];
         end
         alu_pkg::op_ror:
         begin
            res = rot[31:0];
            c_out = (shamt != 5'h0) ? rot[31] : flags[`FLG_C];
            v_out = flags[`FLG_V];
         end
         default: ;
      endcase
      upd_cv = !(op inside {alu_pkg::op_and, alu_pkg::op_or, alu_pkg::op_xor, alu_pkg::op_mov,
                            alu_pkg::op_and_with_inverse, alu_pkg::op_max, alu_pkg::op_min,
                            alu_pkg::op_single_bit_set, alu_pkg::op_single_bit_clear,
                            alu_pkg::op_single_bit_toggle, alu_pkg::op_low_bit_mask});
   end

   // ----------------------------------------
   // Commit
   // ----------------------------------------
   wire logic executes = go && cond_pass && !refused;
   wire logic reg_write = executes && !discard;
   wire logic flag_write = executes && setf;
   wire logic [3:0] next_flags = {upd_cv ? v_out : flags[`FLG_V],
                                  upd_cv ? c_out : flags[`FLG_C],
                                  res[31], res == 32'h0};

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         insn <= `RST_WORD;
         fields <= `RST_WORD;
         imm <= `RST_WORD;
         limm <= `RST_WORD;
         go <= 1'b0;
      end
      else
      begin
         insn <= (wr && hit_insn) ? merge(insn, pwdata, pstrb) : insn;
         fields <= (wr && hit_fields) ? merge(fields, pwdata, pstrb) : fields;
         imm <= (wr && hit_imm) ? merge(imm, pwdata, pstrb) : imm;
         limm <= (wr && hit_limm) ? merge(limm, pwdata, pstrb) : limm;
         go <= wr && hit_go;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         flags <= `RST_FLAGS;
         result <= `RST_WORD;
         refused_q <= 1'b0;
         skipped_q <= 1'b0;
         done_q <= 1'b0;
      end
      else if (go)
      begin
         flags <= flag_write ? next_flags : flags;
         result <= res;
         refused_q <= refused;
         skipped_q <= !cond_pass;
         done_q <= 1'b1;
      end
      else if (wr && hit_status && pstrb[0])
         flags <= pwdata[`ST_FLAGS];
   end

   always_ff @(posedge pclk)
   begin
      if (reg_write)
         rf[idx_a] <= res;
      else if (wr && hit_rf)
         rf[rf_addr] <= merge(rf[rf_addr], pwdata, pstrb);
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         prdata <= `RST_WORD;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= access;
         prdata <= (access && !pwrite) ? rdata_mux : `RST_WORD;
         pslverr <= access && !mapped;
      end
   end

endmodule

`default_nettype wire

//--- verification/apb_master_model.sv
/*
   APB master standing in for the decode stage.
   Assumes one slave on pclk that answers with pready.
*/
`timescale 1ns/1ps
`default_nettype none
module apb_master_model
(
   input wire logic pclk,
   output logic [11:0] paddr,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [31:0] pwdata,
   output logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   logic [31:0] rdata;
   logic rerr;

   initial
   begin
      paddr = 12'h000;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      pwdata = 32'h0000_0000;
      pstrb = 4'hf;
   end

   task xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Released lines do not keep their value
      paddr <= ~a;
      pwrite <= ~wr;
      pwdata <= ~d;
   endtask
endmodule
`default_nettype wire

//--- verification/base_alu_datapath_sva.sv
/*
   Checker of the datapath's APB port.
   Assumes it is bound to the datapath top module.
*/
`timescale 1ns/1ps
`default_nettype none
module base_alu_datapath_sva
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   wire logic mapped = paddr[11:8] == 4'h1 || (paddr[11:5] == 7'h00 && paddr[4:2] != 3'h7);

   a_ready_wait: assert property (psel && penable && !pready |=> pready)
      else $error("no answer after access edge");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_ready_cause: assert property (pready |-> $past(psel) && $past(penable) && !$past(pready))
      else $error("pready without access");
   a_setup_span: assert property ($rose(psel) |-> !pready [*2] ##1 pready)
      else $error("transfer length wrong");
   a_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000)
      else $error("read data outside answer");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("error without pready");
   a_err_decode: assert property (pready && paddr[1:0] == 2'h0 |-> pslverr == !mapped)
      else $error("error flag against address map");
   a_err_rdata: assert property (pready && pslverr |-> prdata == 32'h0000_0000)
      else $error("refused read returns data");
   a_go_reads_zero: assert property (pready && !pwrite && paddr == 12'h010
      |-> prdata == 32'h0000_0000)
      else $error("trigger register reads nonzero");
endmodule
`default_nettype wire

//--- verification/base_alu_datapath_tb_top.sv
/*
   Bench of the ALU datapath: runs operations over APB and compares results.
   Assumes the APB master model and the checker are compiled first.
*/
`include "alu_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module base_alu_datapath_tb_top;
   localparam logic [3:0] C_AL = alu_pkg::cond_always;
   localparam logic [2:0] S_REG = alu_pkg::src2_reg;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic [11:0] paddr;
   logic psel;
   logic penable;
   logic pwrite;
   logic [31:0] pwdata;
   logic [3:0] pstrb;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   int err_count = 0;
   int n_tests = 0;
   int i;
   int p;
   logic [31:0] rv;
   logic [31:0] res;
   logic [31:0] e;
   logic [6:0] st;
   logic [31:0] bv [2] = '{32'h8000_00f5, 32'h0000_1234};
   logic [31:0] cv [2] = '{32'h0000_0007, 32'hffff_fffe};
   logic [4:0] no_short [10] = '{5'h01, 5'h03, 5'h04, 5'h13, 5'h14, 5'h15, 5'h19, 5'h0a,
      5'h09, 5'h1a};

   always #50 pclk = ~pclk;

   apb_master_model i_apb_master_model (.pclk(pclk), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr));
   base_alu_datapath i_base_alu_datapath (.pclk(pclk), .presetn(presetn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr));

   task final_report();
      $display("comparisons %0d, mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         err_count++;
         $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   task wr(input logic [11:0] a, input logic [31:0] d);
      i_apb_master_model.xfer(1'b1, a, d);
   endtask

   task rd(input logic [11:0] a);
      i_apb_master_model.xfer(1'b0, a, 32'h0000_0000);
      rv = i_apb_master_model.rdata;
   endtask

   task wrf(input int r, input logic [31:0] d);
      wr(12'h100 + 12'(r * 4), d);
   endtask

   task rdr(input int r);
      rd(12'h100 + 12'(r * 4));
   endtask

   task pre(input logic [31:0] b, input logic [31:0] c);
      wrf(1, b);
      wrf(2, c);
      wrf(3, 32'h0000_0000);
   endtask

   function automatic logic [15:0] mk(input logic [4:0] op, input logic f,
      input logic [3:0] cc, input logic s1, input logic [2:0] s2);
      return {1'b0, s2, s1, cc, f, 1'b0, op};
   endfunction

   function automatic logic [31:0] fl(input logic [5:0] a, input logic [5:0] b,
      input logic [5:0] c);
      return {10'h000, c, 2'h0, b, 2'h0, a};
   endfunction

   // Result of one long-form operation on two register operands
   function automatic logic [31:0] model(input logic [4:0] op, input logic [31:0] b,
      input logic [31:0] c, input logic ci);
      logic [4:0] n;
      n = c[4:0];
      case (op)
         5'h00: return b + c;
         5'h01: return b + c + 32'(ci);
         5'h02: return b - c;
         5'h03: return b - c - 32'(ci);
         5'h04: return c - b;
         5'h05: return b & c;
         5'h06: return b | c;
         5'h07: return b & ~c;
         5'h08: return b ^ c;
         5'h09: return ($signed(b) > $signed(c)) ? b : c;
         5'h0a: return ($signed(b) < $signed(c)) ? b : c;
         5'h0b: return c;
         5'h0c: return b | (32'h1 << n);
         5'h0d: return b & ~(32'h1 << n);
         5'h0e: return b ^ (32'h1 << n);
         5'h0f: return b & (32'hffff_ffff >> (5'h1f - n));
         5'h10: return b + (c << 1);
         5'h11: return b + (c << 2);
         5'h12: return b + (c << 3);
         5'h13: return b - (c << 1);
         5'h14: return b - (c << 2);
         5'h15: return b - (c << 3);
         5'h16: return b << n;
         5'h17: return $signed(b) >>> n;
         5'h18: return b >> n;
         default: return (b >> n) | (b << (6'h20 - 6'(n)));
      endcase
   endfunction

   task run(input logic [15:0] insn, input logic [31:0] flds, input logic [31:0] imm,
      input logic [31:0] limm, input logic [3:0] flg);
      wr(`OFS_STATUS, {28'h0000000, flg});
      wr(`OFS_FIELDS, flds);
      wr(`OFS_IMM, imm);
      wr(`OFS_LIMM, limm);
      wr(`OFS_INSN, {16'h0000, insn});
      wr(`OFS_GO, 32'h0000_0000);
      rd(`OFS_RESULT);
      res = rv;
      rd(`OFS_STATUS);
      st = rv[6:0];
   endtask

   initial
   begin
      repeat (30000) @(posedge pclk);
      err_count++;
      final_report();
   end

   initial
   begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      rd(`OFS_STATUS);
      check(rv, `RST_WORD);
      rd(`OFS_RESULT);
      check(rv, `RST_WORD);
      rd(12'h01c);
      check({rv[31:1], i_apb_master_model.rerr}, 32'h0000_0001);
      rd(`OFS_GO);
      check(rv, 32'h0000_0000);
      for (p = 0; p < 2; p++)
         for (i = 0; i < 26; i++)
         begin
            pre(bv[p], cv[p]);
            run(mk(i[4:0], 1'b1, C_AL, 1'b0, S_REG), fl(6'h03, 6'h01, 6'h02), 0, 0, 4'h4);
            e = model(i[4:0], bv[p], cv[p], 1'b1);
            check(res, e);
            rdr(3);
            check(rv, e);
            check({st[6:4], st[1:0]}, {3'b100, e[31], e == 32'h0});
         end
      pre(32'h0000_0005, 32'h0000_0003);
      wrf(0, 32'h0000_1111);
      run(mk(5'h00, 1'b0, C_AL, 1'b0, S_REG), fl(6'h00, 6'h01, 6'h02), 0, 0, 4'ha);
      check(res, 32'h0000_0008);
      check(st[3:0], 4'ha);
      rdr(0);
      check(rv, 32'h0000_1111);
      run(mk(5'h00, 1'b1, alu_pkg::cond_zero, 1'b0, S_REG), fl(6'h01, 6'h01, 6'h02), 0, 0, 4'h0);
      check(st[5:0], 6'h20);
      rdr(1);
      check(rv, 32'h0000_0005);
      run(mk(5'h00, 1'b1, alu_pkg::cond_zero, 1'b0, S_REG), fl(6'h01, 6'h01, 6'h02), 0, 0, 4'h1);
      check(st[5:0], 6'h00);
      rdr(1);
      check(rv, 32'h0000_0008);
      foreach (no_short[k])
      begin
         run(mk(no_short[k], 1'b1, C_AL, 1'b0, S_REG) | 16'h0020, fl(6'h03, 6'h01, 6'h02),
            0, 0, 4'h0);
         check(st[5:0], 6'h10);
      end
      rdr(3);
      check(rv, 32'h0000_0000);
      run(mk(5'h00, 1'b0, C_AL, 1'b0, alu_pkg::src2_u6), fl(6'h03, 6'h01, 6'h3f), 0, 0, 4'h0);
      check(res, 32'h0000_0047);
      run(mk(5'h02, 1'b0, C_AL, 1'b1, S_REG), fl(6'h03, 6'h00, 6'h02), 0, 32'h100, 4'h0);
      check(res, 32'h0000_00fd);
      run(mk(5'h02, 1'b0, C_AL, 1'b0, alu_pkg::src2_limm), fl(6'h03, 6'h01, 6'h00), 0,
         32'h100, 4'h0);
      check(res, 32'hffff_ff08);
      run(mk(5'h00, 1'b0, C_AL, 1'b0, alu_pkg::src2_s12), fl(6'h03, 6'h01, 6'h00), 32'h800,
         0, 4'h0);
      check(res, 32'hffff_f808);
      pre(32'h0000_0005, 32'h0000_0003);
      run(mk(5'h00, 1'b0, C_AL, 1'b0, S_REG) | 16'h0020, fl(6'h05, 6'h01, 6'h02), 0, 0, 4'h0);
      rdr(13);
      check(rv, 32'h0000_0008);
      wrf(26, 32'h0000_0100);
      run(mk(5'h00, 1'b0, C_AL, 1'b0, S_REG) | 16'h8020, fl(6'h01, 6'h01, 6'h1a), 0, 0, 4'h0);
      rdr(1);
      check(rv, 32'h0000_0105);
      run(mk(5'h02, 1'b0, C_AL, 1'b0, S_REG) | 16'h0020, fl(6'h02, 6'h02, 6'h02), 0, 0, 4'h1);
      rdr(2);
      check(rv, 32'h0000_0003);
      run(mk(5'h02, 1'b0, C_AL, 1'b0, S_REG) | 16'h0020, fl(6'h02, 6'h02, 6'h02), 0, 0, 4'h0);
      rdr(2);
      check(rv, 32'h0000_0000);
      wrf(28, 32'h0000_1000);
      run(mk(5'h02, 1'b0, C_AL, 1'b0, alu_pkg::src2_u7_words) | 16'h0020,
         fl(6'h00, 6'h00, 6'h00), 32'h7f, 0, 4'h0);
      rdr(28);
      check(rv, 32'h0000_0e04);
      pre(32'hffff_ffff, 32'h0000_0001);
      run(mk(5'h00, 1'b1, C_AL, 1'b0, S_REG), fl(6'h03, 6'h01, 6'h02), 0, 0, 4'h0);
      check(st[3:0], 4'h5);
      pre(32'h7fff_ffff, 32'h0000_0001);
      run(mk(5'h00, 1'b1, C_AL, 1'b0, S_REG), fl(6'h03, 6'h01, 6'h02), 0, 0, 4'h0);
      check(st[3:0], 4'ha);
      pre(32'h0000_0000, 32'h0000_0001);
      run(mk(5'h02, 1'b1, C_AL, 1'b0, S_REG), fl(6'h03, 6'h01, 6'h02), 0, 0, 4'h0);
      check(st[3:0], 4'h6);
      final_report();
   end
endmodule

bind base_alu_datapath base_alu_datapath_sva i_base_alu_datapath_sva (.pclk(pclk),
   .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
   .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));
`default_nettype wire
